// *** cmp_decide.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cmp_timing_consts.svh"
// Digital model of the sampled-data comparator core. The positive input is
// taken while the link clock is high, the negative input while it is low.
module cmp_decide #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk_high,
    input wire logic sample_pos_now,
    input wire logic sample_neg_now,
    input wire logic [WIDTH-1:0] pos_in,
    input wire logic [WIDTH-1:0] neg_in,
    input wire logic [WIDTH-1:0] threshold_level,
    output logic zeroing,
    output logic decision
);
    logic [WIDTH-1:0] pos_held;
    logic [WIDTH-1:0] next_pos_held;
    logic next_decision;
    logic [WIDTH:0] diff;

    assign zeroing = link_clk_high;

    always_comb begin
        next_pos_held = pos_held;
        next_decision = decision;
        diff = {1'b0, pos_held} - {1'b0, neg_in};
        if (sample_pos_now) begin
            next_pos_held = pos_in;
        end
        if (sample_neg_now) begin
            if (pos_held <= neg_in) begin
                next_decision = 1'b0;
            end else begin
                next_decision = (diff[WIDTH-1:0] > threshold_level);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pos_held <= '0;
            decision <= 1'b0;
        end else begin
            pos_held <= next_pos_held;
            decision <= next_decision;
        end
    end
endmodule
`default_nettype wire

// *** cmp_timing.sv ***
// Behaviour
// - With select low and programmed, a new decision appears at each falling link edge after the first.
// - Shown decision comes from the comparison finished half a link cycle earlier.
// - Positive input sampled while link clock high, negative while low.
// - Each comparison has a zeroing phase then a comparing phase.
// - Positive input step reaches output within one to two link cycles.
// - Negative input step reaches output within half to one and a half cycles.
// - Negative at or above positive gives a zero decision.
// - Select high releases the result output and keeps it released.
// - Output driver turns on at the rising link edge that ends programming.
// - Pulses changing late in a half period may be missed.
// - Configuration input captured on rising link edges.
// - Input difference compared against threshold set by the eight-bit code.
// - Leading zeros ignored; first one is the start bit.
// - Start bit, then two or three channel bits, then code LSB first.
// - After programming ignore config input; output undefined for 1.5 link cycles.
// - Select high clears the state, code, channel and output registers; new comparison needs full reprogramming.
`timescale 1ns/1ps
`default_nettype none
`include "cmp_timing_consts.svh"
module cmp_timing #(
    parameter int CHAN_BITS = `CHAN_BITS_LONG,
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic select_n,
    input wire logic link_clk,
    input wire logic serial_config_in,
    input wire logic [WIDTH-1:0] pos_in,
    input wire logic [WIDTH-1:0] neg_in,
    output logic result_out,
    output logic result_oe,
    output logic [CHAN_BITS-1:0] channel_sel,
    output logic [`CODE_BITS-1:0] threshold_level,
    output logic zeroing,
    output logic programmed
);
    initial begin
        if (CHAN_BITS != `CHAN_BITS_SHORT && CHAN_BITS != `CHAN_BITS_LONG) begin
            $error("CHAN_BITS must be 2 or 3");
        end
        if (WIDTH != `CODE_BITS) begin
            $error("WIDTH must equal the code width");
        end
    end

    logic sel_n_s1, sel_n_s2, lclk_s1, lclk_s2, din_s1, din_s2, lclk_d;
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_n_s1 <= 1'b1;
            sel_n_s2 <= 1'b1;
            lclk_s1 <= 1'b0;
            lclk_s2 <= 1'b0;
            lclk_d <= 1'b0;
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
        end else begin
            sel_n_s1 <= select_n;
            sel_n_s2 <= sel_n_s1;
            lclk_s1 <= link_clk;
            lclk_s2 <= lclk_s1;
            lclk_d <= lclk_s2;
            din_s1 <= serial_config_in;
            din_s2 <= din_s1;
        end
    end

    logic rise, fall, clr;
    assign rise = lclk_s2 && !lclk_d;
    assign fall = !lclk_s2 && lclk_d;
    assign clr = sel_n_s2;

    cmp_timing_pkg::prog_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [CHAN_BITS-1:0] next_channel_sel;
    logic [`CODE_BITS-1:0] next_threshold_level;
    logic next_result_out, next_result_oe;
    logic settle, next_settle;
    logic decision;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_channel_sel = channel_sel;
        next_threshold_level = threshold_level;
        next_result_out = result_out;
        next_result_oe = result_oe;
        next_settle = settle;
        if (clr) begin
            next_state = cmp_timing_pkg::ST_IDLE;
            next_cnt = 4'h0;
            next_channel_sel = '0;
            next_threshold_level = `CODE_RESET;
            next_result_oe = 1'b0;
            next_result_out = 1'b0;
            next_settle = 1'b0;
        end else if (rise) begin
            unique case (state)
                cmp_timing_pkg::ST_IDLE: begin
                    if (din_s2) begin
                        next_state = cmp_timing_pkg::ST_CHAN;
                        next_cnt = 4'h0;
                    end
                end
                cmp_timing_pkg::ST_CHAN: begin
                    next_channel_sel = {channel_sel[CHAN_BITS-2:0], din_s2};
                    next_cnt = cnt + 4'h1;
                    if (cnt == 4'(CHAN_BITS - 1)) begin
                        next_state = cmp_timing_pkg::ST_CODE;
                        next_cnt = 4'h0;
                    end
                end
                cmp_timing_pkg::ST_CODE: begin
                    next_threshold_level = {din_s2, threshold_level[`CODE_BITS-1:1]};
                    next_cnt = cnt + 4'h1;
                    if (cnt == 4'(`CODE_BITS - 1)) begin
                        next_state = cmp_timing_pkg::ST_RUN;
                        next_result_oe = 1'b1;
                        next_settle = 1'b1;
                    end
                end
                cmp_timing_pkg::ST_RUN: begin
                    next_state = cmp_timing_pkg::ST_RUN;
                end
            endcase
        end else if (fall && state == cmp_timing_pkg::ST_RUN) begin
            // first fall is the undefined slot; update on fall only
            if (settle) begin
                next_settle = 1'b0;
            end else begin
                next_result_out = decision;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= cmp_timing_pkg::ST_IDLE;
            cnt <= 4'h0;
            channel_sel <= '0;
            threshold_level <= `CODE_RESET;
            result_out <= 1'b0;
            result_oe <= 1'b0;
            settle <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            channel_sel <= next_channel_sel;
            threshold_level <= next_threshold_level;
            result_out <= next_result_out;
            result_oe <= next_result_oe;
            settle <= next_settle;
        end
    end

    assign programmed = (state == cmp_timing_pkg::ST_RUN);

    cmp_decide #(.WIDTH(WIDTH)) u_decide (
        .clk(clk),
        .rst(rst),
        .link_clk_high(lclk_s2 && programmed),
        .sample_pos_now(fall && programmed),
        .sample_neg_now(rise && programmed && !clr),
        .pos_in(pos_in),
        .neg_in(neg_in),
        .threshold_level(threshold_level),
        .zeroing(zeroing),
        .decision(decision)
    );

    AST_RELEASE: assert property (@(posedge clk) disable iff (rst)
        sel_n_s2 |=> !result_oe) else $error("output driven while deselected");
    AST_ENABLE: assert property (@(posedge clk) disable iff (rst)
        $rose(result_oe) |-> $past(rise) && $past(state == cmp_timing_pkg::ST_CODE))
        else $error("driver enabled at wrong time");
    AST_HOLD: assert property (@(posedge clk) disable iff (rst)
        result_oe && $changed(result_out) |-> $past(fall))
        else $error("output changed away from falling edge");
    AST_ZERO: assert property (@(posedge clk) disable iff (rst)
        (rise && programmed && !clr && u_decide.pos_held <= neg_in) |=> !decision)
        else $error("nonzero decision with negative at or above positive");
    AST_IGNORE: assert property (@(posedge clk) disable iff (rst)
        programmed && !clr |=> $stable(threshold_level) && $stable(channel_sel))
        else $error("configuration changed after programming");
    AST_CLEAR: assert property (@(posedge clk) disable iff (rst)
        sel_n_s2 |=> !programmed && threshold_level == `CODE_RESET)
        else $error("state not cleared by select");
    AST_START: assert property (@(posedge clk) disable iff (rst)
        state == cmp_timing_pkg::ST_IDLE && rise && !din_s2 |=> state == cmp_timing_pkg::ST_IDLE)
        else $error("zero taken as start bit");
    // fresh decision taken at a fall once settled
    AST_FRESH: assert property (@(posedge clk) disable iff (rst)
        fall && programmed && !settle && !clr |=> result_out == $past(decision))
        else $error("decision not presented at falling edge");
    sequence seq_first_fall;
        fall && programmed && settle && !clr;
    endsequence
    AST_SETTLE: assert property (@(posedge clk) disable iff (rst)
        seq_first_fall |=> $stable(result_out) && !settle)
        else $error("output updated in the undefined slot");
endmodule
`default_nettype wire

// *** cmp_timing_consts.svh ***
`ifndef CMP_TIMING_CONSTS_SVH
`define CMP_TIMING_CONSTS_SVH

// Width of the programmed threshold code.
`define CODE_BITS 8
// Channel word length for the two-input and four-input variants.
`define CHAN_BITS_SHORT 2
`define CHAN_BITS_LONG 3
// Reset values.
`define CODE_RESET 8'h00
`define CHAN_RESET 3'h0

`endif

// *** cmp_timing_pkg.sv ***
package cmp_timing_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CHAN,
        ST_CODE,
        ST_RUN
    } prog_state_t;
endpackage

// *** host_link_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_link_model #(
    parameter int HALF = 64
) (
    input wire logic clk,
    output logic select_n,
    output logic link_clk,
    output logic serial_config_in
);
    logic active = 1'b0;
    logic spare = 1'b0;
    int cnt = 0;
    initial begin
        select_n = 1'b1;
        link_clk = 1'b0;
        serial_config_in = 1'b0;
    end
    // link rate bound
    // The link clock stands still low outside frames.
    always @(negedge clk) begin
        if (!active) begin
            cnt = 0;
            link_clk = 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt = 0;
            link_clk = ~link_clk;
        end else begin
            cnt = cnt + 1;
        end
    end
    // After programming the line keeps changing so stale bits cannot pass for data.
    always @(negedge link_clk) begin
        if (spare) begin
            serial_config_in = ~serial_config_in;
        end
    end
    task automatic send_setup(input logic [2:0] chan, input logic [7:0] code, input int lead);
        logic [19:0] seq;
        int n;
        seq = 20'({code, chan[0], chan[1], chan[2], 1'b1}) << lead;
        n = lead + 12;
        select_n = 1'b0;
        active = 1'b1;
        for (int i = 0; i < n; i++) begin
            serial_config_in = seq[i];
            @(posedge link_clk);
            if (i < n - 1) @(negedge link_clk);
        end
        spare = 1'b1;
    endtask
    task automatic release_link();
        @(negedge link_clk);
        active = 1'b0;
        spare = 1'b0;
        select_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] pos_in = 8'h00;
    logic [7:0] neg_in = 8'h00;
    logic select_n;
    logic link_clk;
    logic serial_config_in;
    logic result_out;
    logic result_oe;
    logic zeroing;
    logic programmed;
    logic [2:0] channel_sel;
    logic [7:0] threshold_level;
    logic exp_q[$];
    logic [2:0] chan;
    logic [7:0] code;
    logic [7:0] vp;
    logic [7:0] vn;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #10 clk = ~clk;

    host_link_model #(.HALF(64)) host (.clk(clk), .select_n(select_n), .link_clk(link_clk),
        .serial_config_in(serial_config_in));
    cmp_timing #(.CHAN_BITS(3), .WIDTH(8)) uut (.clk(clk), .rst(rst), .select_n(select_n),
        .link_clk(link_clk), .serial_config_in(serial_config_in), .pos_in(pos_in),
        .neg_in(neg_in), .result_out(result_out), .result_oe(result_oe),
        .channel_sel(channel_sel), .threshold_level(threshold_level), .zeroing(zeroing),
        .programmed(programmed));

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%0h want=%0h", $time, seen, want);
        end
    endtask

    task automatic wrap_up();
        $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic prog_run(input int lead);
        chan = 3'($urandom);
        code = 8'($urandom_range(100));
        host.send_setup(chan, code, lead);
        check(8'(result_oe), 8'h00);
        repeat (6) @(posedge clk);
        #1;
        check(8'(result_oe), 8'h01);
        check(threshold_level, code);
        check(8'(channel_sel), 8'(chan));
    endtask

    task automatic run_vector(input logic [7:0] p, input logic [7:0] n);
        logic want;
        want = (p > n) && (p - n > code);
        @(negedge link_clk);
        @(negedge clk);
        pos_in = p;
        neg_in = n;
        @(negedge link_clk);
        @(posedge link_clk);
        repeat (10) @(posedge clk);
        #1;
        check(8'(zeroing), 8'h01);
        exp_q.push_back(want);
        exp_q.push_back(want);
        @(negedge link_clk);
        repeat (10) @(posedge clk);
        #1;
        check(8'(zeroing), 8'h00);
        @(negedge link_clk);
    endtask

    // Each queued note is compared once the decision of that fall has settled.
    always @(negedge link_clk) begin
        repeat (8) @(posedge clk);
        #1;
        if (exp_q.size() > 0) begin
            check(8'(result_out), 8'(exp_q.pop_front()));
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(32'h2C32E1C8));
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check(8'(result_oe), 8'h00);
        prog_run(3);
        for (int i = 0; i < 20; i++) begin
            vn = 8'($urandom_range(100));
            case (i % 4)
                0: vp = vn;
                1: begin
                    vp = vn;
                    vn = vn + 8'($urandom_range(1, 50));
                end
                2: vp = vn + code;
                default: vp = vn + code + 8'h01;
            endcase
            run_vector(vp, vn);
            if (i == 15) begin
                check(threshold_level, code);
                host.release_link();
                repeat (8) @(negedge clk);
                check(8'(result_oe), 8'h00);
                check(8'(programmed), 8'h00);
                check(threshold_level, 8'h00);
                prog_run(0);
            end
        end
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check(8'(result_oe), 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
